/* File: core/lcd_mode_and_address_decoder.v */
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "lcd_decoder_defines.vh"

module lcd_mode_and_address_decoder #(
   parameter [31:0] BLINK_HALF_CYCLES = (`BLINK_MS * `CLK_KHZ) / 2
) (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // Host instruction pins
   input  wire        host_strobe,
   input  wire        command_data_select,
   input  wire        read_write,
   input  wire [7:0]  host_db,
   // Mode state
   output reg         step_increment,
   output reg         shift_on_write,
   output reg         display_enable,
   output reg         cursor_enable,
   output reg         blink_enable,
   output reg         bus_width_select,
   output reg         two_line_mode,
   output reg  [6:0]  address_pointer,
   output reg         text_target,
   output reg  [4:0]  display_offset,
   output reg         internal_busy_flag,
   // Panel view
   output reg         panel_blank,
   output reg         cursor_line,
   output reg  [4:0]  cursor_column,
   output reg         cursor_underline_on,
   output reg  [2:0]  cursor_dot_row,
   output reg  [4:0]  cursor_dot_mask,
   output reg         blink_all_on,
   // AXI4-Lite write
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   // ----------------------------------------
   // Byte assembly and blink rate
   // ----------------------------------------
   wire       byte_valid;
   wire       byte_sel;
   wire       byte_rw;
   wire [7:0] byte_val;
   wire       blink_phase;

   // Strobes arriving while busy never reach the assembler
   nibble_pair_assembler u_pair (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .strobe        (host_strobe & ~internal_busy_flag),
      .sel_in        (command_data_select),
      .rw_in         (read_write),
      .db_in         (host_db),
      .wide_mode     (bus_width_select),
      .byte_valid_ff (byte_valid),
      .sel_ff        (byte_sel),
      .rw_ff         (byte_rw),
      .byte_ff       (byte_val)
   );

   blink_timer #(
      .HALF_CYCLES (BLINK_HALF_CYCLES)
   ) u_blink (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (blink_enable),
      .phase_ff (blink_phase)
   );

   // ----------------------------------------
   // Instruction classification
   // ----------------------------------------
   wire is_cmd   = byte_valid & ~byte_sel & ~byte_rw;
   wire is_data  = byte_valid & byte_sel;
   wire is_write = is_data & ~byte_rw;

   reg op_entry;
   reg op_disp;
   reg op_shift;
   reg op_func;
   reg op_glyph;
   reg op_text;

   // Only the highest set bit picks the class; lower bits are fields
   always @* begin
      op_entry = 1'b0;
      op_disp  = 1'b0;
      op_shift = 1'b0;
      op_func  = 1'b0;
      op_glyph = 1'b0;
      op_text  = 1'b0;
      if (is_cmd) begin
         if (byte_val[`BIT_TEXT_ADDR])
            op_text = 1'b1;
         else if (byte_val[`BIT_GLYPH_ADDR])
            op_glyph = 1'b1;
         else if (byte_val[`BIT_FUNC_SET])
            op_func = 1'b1;
         else if (byte_val[`BIT_SHIFT])
            op_shift = 1'b1;
         else if (byte_val[`BIT_DISP_CTRL])
            op_disp = 1'b1;
         else if (byte_val[`BIT_ENTRY])
            op_entry = 1'b1;
      end
   end

   // ----------------------------------------
   // Pointer stepping with line wrap
   // ----------------------------------------
   reg [6:0] ptr_up;
   reg [6:0] ptr_down;

   // Text pointer follows the visible layout; glyph pointer wraps in 5 bits
   always @* begin
      ptr_up   = address_pointer + 7'h01;
      ptr_down = address_pointer - 7'h01;
      if (!text_target) begin
         ptr_up   = {2'h0, ptr_up[4:0]};
         ptr_down = {2'h0, ptr_down[4:0]};
      end else if (two_line_mode) begin
         if (address_pointer == `LINE1_LAST)
            ptr_up = `LINE2_BASE;
         else if (address_pointer == `LINE2_LAST)
            ptr_up = 7'h00;
         if (address_pointer == `LINE2_BASE)
            ptr_down = `LINE1_LAST;
         else if (address_pointer == 7'h00)
            ptr_down = `LINE2_LAST;
      end else begin
         if (address_pointer == `ONE_LINE_LAST)
            ptr_up = 7'h00;
         if (address_pointer == 7'h00)
            ptr_down = `ONE_LINE_LAST;
      end
   end

   // ----------------------------------------
   // Display offset shared by both lines
   // ----------------------------------------
   wire [4:0] line_len = two_line_mode ? `LEN_TWO_LINE : `LEN_ONE_LINE;
   wire [4:0] off_left  = (display_offset == line_len - 5'h01) ? 5'h00
                          : display_offset + 5'h01;
   wire [4:0] off_right = (display_offset == 5'h00) ? line_len - 5'h01
                          : display_offset - 5'h01;

   // ----------------------------------------
   // Mode registers and pointer
   // ----------------------------------------
   reg [6:0] nxt_ptr;
   reg [4:0] nxt_off;
   reg       nxt_text;

   // One offset moves both lines horizontally, so no text crosses lines
   always @* begin
      nxt_ptr  = address_pointer;
      nxt_off  = display_offset;
      nxt_text = text_target;
      if (op_text) begin
         nxt_ptr  = byte_val[6:0];
         nxt_text = 1'b1;
      end else if (op_glyph) begin
         nxt_ptr  = {2'h0, byte_val[4:0]};
         nxt_text = 1'b0;
      end else if (op_shift) begin
         case (byte_val[`F_SHIFT_TARGET:`F_SHIFT_RIGHT])
            2'h0:    nxt_ptr = ptr_down;
            2'h1:    nxt_ptr = ptr_up;
            2'h2:    nxt_off = off_left;
            2'h3:    nxt_off = off_right;
            default: nxt_ptr = address_pointer;
         endcase
      end else if (op_func) begin
         nxt_off = 5'h00;                        // Offset range follows line count
      end else if (is_data) begin
         nxt_ptr = step_increment ? ptr_up : ptr_down;
         if (is_write && shift_on_write && text_target)
            nxt_off = step_increment ? off_left : off_right;
      end
   end

   // Reset comes up in wide mode, one line, display off, stepping up
   always @(posedge aclk) begin
      if (!aresetn) begin
         step_increment   <= 1'b1;
         shift_on_write   <= 1'b0;
         display_enable   <= 1'b0;
         cursor_enable    <= 1'b0;
         blink_enable     <= 1'b0;
         bus_width_select <= 1'b1;
         two_line_mode    <= 1'b0;
         address_pointer  <= 7'h00;
         text_target      <= 1'b1;
         display_offset   <= 5'h00;
      end else begin
         address_pointer <= nxt_ptr;
         display_offset  <= nxt_off;
         text_target     <= nxt_text;
         if (op_entry) begin
            step_increment <= byte_val[`F_STEP_DIR];
            shift_on_write <= byte_val[`F_SHIFT_WRITE];
         end
         if (op_disp) begin
            display_enable <= byte_val[`F_DISP_EN];
            cursor_enable  <= byte_val[`F_CURSOR_EN];
            blink_enable   <= byte_val[`F_BLINK_EN];
         end
         // Font size bit is not looked at: the glyph grid never changes
         if (op_func) begin
            bus_width_select <= byte_val[`F_BUS_WIDTH];
            two_line_mode    <= byte_val[`F_LINES];
         end
      end
   end

   // ----------------------------------------
   // Busy window after each accepted byte
   // ----------------------------------------
   reg [7:0] busy_time_ff;
   reg [7:0] busy_cnt_ff;
   reg [7:0] nxt_busy_cnt;

   always @* begin
      nxt_busy_cnt = busy_cnt_ff;
      if (byte_valid)
         nxt_busy_cnt = busy_time_ff;
      else if (busy_cnt_ff != 8'h00)
         nxt_busy_cnt = busy_cnt_ff - 8'h01;
   end

   // A zero busy time lets instructions run back to back
   always @(posedge aclk) begin
      if (!aresetn) begin
         busy_cnt_ff        <= 8'h00;
         internal_busy_flag <= 1'b0;
      end else begin
         busy_cnt_ff        <= nxt_busy_cnt;
         internal_busy_flag <= (nxt_busy_cnt != 8'h00);
      end
   end

   // ----------------------------------------
   // Cursor position on the panel
   // ----------------------------------------
   reg [5:0] col_raw;
   reg [5:0] col_fix;

   // Visible column is the pointer minus the shared offset, modulo line length
   always @* begin
      col_raw = {1'b0, address_pointer[4:0]} - {1'b0, display_offset};
      col_fix = col_raw[5] ? col_raw + {1'b0, line_len} : col_raw;
   end

   // The cursor and blink share one cell and may both show
   always @(posedge aclk) begin
      if (!aresetn) begin
         panel_blank         <= 1'b1;
         cursor_line         <= 1'b0;
         cursor_column       <= 5'h00;
         cursor_underline_on <= 1'b0;
         cursor_dot_row      <= `CURSOR_DOT_ROW;
         cursor_dot_mask     <= `CURSOR_DOT_MASK;
         blink_all_on        <= 1'b0;
      end else begin
         panel_blank         <= ~display_enable;
         cursor_line         <= two_line_mode & address_pointer[6];
         cursor_column       <= col_fix[4:0];
         cursor_underline_on <= display_enable & cursor_enable;
         cursor_dot_row      <= `CURSOR_DOT_ROW;
         cursor_dot_mask     <= `CURSOR_DOT_MASK;
         blink_all_on        <= display_enable & blink_enable & blink_phase;
      end
   end

   // ----------------------------------------
   // AXI4-Lite register slave
   // ----------------------------------------
   reg        aw_held_ff;
   reg        w_held_ff;
   reg [3:0]  awaddr_ff;
   reg [31:0] wdata_ff;
   reg [3:0]  wstrb_ff;

   // Address and data are caught in either order; one write at a time
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff    <= 1'b0;
         w_held_ff     <= 1'b0;
         awaddr_ff     <= 4'h0;
         wdata_ff      <= 32'h0;
         wstrb_ff      <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         busy_time_ff  <= `BUSY_DEFAULT;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff    <= 1'b1;
            awaddr_ff     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff    <= 1'b1;
            wdata_ff     <= s_axi_wdata;
            wstrb_ff     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_held_ff && w_held_ff && !s_axi_bvalid) begin
            aw_held_ff   <= 1'b0;
            w_held_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_ff == `REG_CTRL) begin
               s_axi_bresp <= `RESP_OKAY;
               if (wstrb_ff[0])
                  busy_time_ff <= wdata_ff[7:0];
            end else if (awaddr_ff == `REG_STATUS || awaddr_ff == `REG_CURSOR) begin
               s_axi_bresp <= `RESP_OKAY;      // Read-only: write dropped
            end else begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Status and cursor words are snapshots taken at the address handshake
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            case (s_axi_araddr)
               `REG_STATUS: s_axi_rdata <= {11'h000, internal_busy_flag, text_target,
                                            display_offset, address_pointer,
                                            two_line_mode, bus_width_select, blink_enable,
                                            cursor_enable, display_enable, shift_on_write,
                                            step_increment};
               `REG_CURSOR: s_axi_rdata <= {24'h000000, blink_all_on, panel_blank,
                                            cursor_line, cursor_column};
               `REG_CTRL:   s_axi_rdata <= {24'h000000, busy_time_ff};
               default: begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // lcd_mode_and_address_decoder

/* File: core/lcd_decoder_defines.vh */
`ifndef LCD_DECODER_DEFINES_VH
`define LCD_DECODER_DEFINES_VH

// ----------------------------------------
// Instruction class bits (highest set bit)
// ----------------------------------------
`define BIT_TEXT_ADDR   7
`define BIT_GLYPH_ADDR  6
`define BIT_FUNC_SET    5
`define BIT_SHIFT       4
`define BIT_DISP_CTRL   3
`define BIT_ENTRY       2

// ----------------------------------------
// Field positions inside each instruction
// ----------------------------------------
`define F_STEP_DIR      1
`define F_SHIFT_WRITE   0
`define F_DISP_EN       2
`define F_CURSOR_EN     1
`define F_BLINK_EN      0
`define F_SHIFT_TARGET  3
`define F_SHIFT_RIGHT   2
`define F_BUS_WIDTH     4
`define F_LINES         3

// ----------------------------------------
// Text layout
// ----------------------------------------
`define ONE_LINE_LAST   7'h17
`define LINE1_LAST      7'h0b
`define LINE2_BASE      7'h40
`define LINE2_LAST      7'h4b
`define LEN_ONE_LINE    5'h18
`define LEN_TWO_LINE    5'h0c
`define CURSOR_DOT_ROW  3'h7
`define CURSOR_DOT_MASK 5'h1f

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_KHZ         125000
`define BLINK_MS        540
`define BUSY_DEFAULT    8'h10

// ----------------------------------------
// Register map and bus answers
// ----------------------------------------
`define REG_STATUS      4'h0
`define REG_CURSOR      4'h4
`define REG_CTRL        4'h8
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* File: core/nibble_pair_assembler.v */
`timescale 1ns/1ps
`include "lcd_decoder_defines.vh"

module nibble_pair_assembler (
   // Clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // Transfers from the pins
   input  wire       strobe,
   input  wire       sel_in,
   input  wire       rw_in,
   input  wire [7:0] db_in,
   input  wire       wide_mode,
   // Whole bytes
   output reg        byte_valid_ff,
   output reg        sel_ff,
   output reg        rw_ff,
   output reg  [7:0] byte_ff
);

   reg       half_ff;
   reg [3:0] high_ff;

   // Narrow mode pairs two upper-lane transfers, high nibble first
   always @(posedge aclk) begin
      if (!aresetn) begin
         half_ff       <= 1'b0;
         high_ff       <= 4'h0;
         byte_valid_ff <= 1'b0;
         sel_ff        <= 1'b0;
         rw_ff         <= 1'b0;
         byte_ff       <= 8'h00;
      end else begin
         byte_valid_ff <= 1'b0;
         if (wide_mode) begin
            half_ff <= 1'b0;             // Realign on a width change
            if (strobe) begin
               byte_valid_ff <= 1'b1;
               sel_ff        <= sel_in;
               rw_ff         <= rw_in;
               byte_ff       <= db_in;
            end
         end else if (strobe) begin
            if (!half_ff) begin
               half_ff <= 1'b1;
               high_ff <= db_in[7:4];
            end else begin
               half_ff       <= 1'b0;
               byte_valid_ff <= 1'b1;
               sel_ff        <= sel_in;
               rw_ff         <= rw_in;
               byte_ff       <= {high_ff, db_in[7:4]};
            end
         end
      end
   end

endmodule // nibble_pair_assembler

/* File: core/blink_timer.v */
`timescale 1ns/1ps
`include "lcd_decoder_defines.vh"

module blink_timer #(
   parameter [31:0] HALF_CYCLES = 32'd33750000
) (
   // Clock and reset
   input  wire aclk,
   input  wire aresetn,
   // Control and phase
   input  wire run,
   output reg  phase_ff
);

   reg [31:0] count_ff;

   // Phase flips every half period; stopping restarts on the dark half
   always @(posedge aclk) begin
      if (!aresetn) begin
         count_ff <= 32'h0;
         phase_ff <= 1'b0;
      end else if (!run) begin
         count_ff <= 32'h0;
         phase_ff <= 1'b0;
      end else if (count_ff >= HALF_CYCLES - 32'h1) begin
         count_ff <= 32'h0;
         phase_ff <= ~phase_ff;
      end else begin
         count_ff <= count_ff + 32'h1;
      end
   end

endmodule // blink_timer

/* File: dv/lcd_decoder_asserts.sv */
`timescale 1ns/1ps
module lcd_decoder_asserts (
   // Clock and reset
   input wire       aclk,
   input wire       aresetn,
   // Host pins
   input wire       host_strobe,
   input wire       command_data_select,
   input wire       read_write,
   input wire [7:0] host_db,
   // Device state
   input wire       step_increment,
   input wire       shift_on_write,
   input wire       display_enable,
   input wire       cursor_enable,
   input wire       blink_enable,
   input wire       bus_width_select,
   input wire       two_line_mode,
   input wire [6:0] address_pointer,
   input wire       text_target,
   input wire       internal_busy_flag
);
   // Whole-byte takes only; nibble pairs are judged by the bench
   wire cmd = host_strobe & ~internal_busy_flag & ~command_data_select & ~read_write & bus_width_select;
   wire dat = host_strobe & ~internal_busy_flag & command_data_select & bus_width_select;
   // ----
   // Fields land two edges after the take
   // ----
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_entry;
      cmd && host_db[7:2] == 6'h01 |-> ##2 {step_increment, shift_on_write} == $past(host_db[1:0], 2);
   endproperty
   a_entry: assert property (p_entry) else $error("entry mode");
   property p_disp;
      cmd && host_db[7:3] == 5'h01 |-> ##2 {display_enable, cursor_enable, blink_enable} == $past(host_db[2:0], 2);
   endproperty
   a_disp: assert property (p_disp) else $error("display control");
   property p_func;
      cmd && host_db[7:5] == 3'h1 |-> ##2 {bus_width_select, two_line_mode} == $past(host_db[4:3], 2);
   endproperty
   a_func: assert property (p_func) else $error("function set");
   property p_text;
      cmd && host_db[7] |-> ##2 text_target && address_pointer == $past(host_db[6:0], 2);
   endproperty
   a_text: assert property (p_text) else $error("text address");
   property p_glyph;
      cmd && host_db[7:6] == 2'h1 |-> ##2 !text_target && address_pointer == {2'h0, $past(host_db[4:0], 2)};
   endproperty
   a_glyph: assert property (p_glyph) else $error("glyph address");
   property p_dshift;
      cmd && host_db[7:3] == 5'h03 |=> ##1 $stable(address_pointer);
   endproperty
   a_dshift: assert property (p_dshift) else $error("display shift moved pointer");
   // A strobe just before could retune the step direction, so it is excluded
   property p_step;
      dat && !$past(host_strobe) && step_increment && address_pointer < 7'h0b
         |-> ##2 address_pointer == $past(address_pointer, 2) + 7'h1;
   endproperty
   a_step: assert property (p_step) else $error("pointer step");
   property p_busy;
      internal_busy_flag [*3] |=> $stable(address_pointer) && $stable(display_enable);
   endproperty
   a_busy: assert property (p_busy) else $error("take while busy");
endmodule // lcd_decoder_asserts
bind lcd_mode_and_address_decoder lcd_decoder_asserts lcd_decoder_asserts_i (.*);

/* File: dv/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
   // Clock and device status
   input wire       aclk,
   input wire       internal_busy_flag,
   // Parallel host pins
   output reg       host_strobe,
   output reg       command_data_select,
   output reg       read_write,
   output reg [7:0] host_db
);
   // Pins idle from time zero
   initial begin
      host_strobe = 1'b0;
      command_data_select = 1'b0;
      read_write = 1'b0;
      host_db = 8'h00;
   end
   // ----
   // One transfer; pol low skips the poll to provoke a refusal
   // ----
   task xfer(input pol, input c, input r, input [7:0] b);
      begin
         @(posedge aclk);
         while (pol && internal_busy_flag !== 1'b0) @(posedge aclk);
         host_strobe <= 1'b1;
         command_data_select <= c;
         read_write <= r;
         host_db <= b;
         @(posedge aclk);
         host_strobe <= 1'b0;
         host_db <= ~b; // No pull on the lines, so show the inverse
         repeat (4) @(posedge aclk); // Busy only shows two edges after the take
      end
   endtask
   // Whole byte; narrow width sends high nibble then low
   task send(input w, input c, input r, input [7:0] b);
      begin
         if (w) xfer(1'b1, c, r, b);
         else begin
            xfer(1'b1, c, r, {b[7:4], ~b[7:4]});
            xfer(1'b1, c, r, {b[3:0], ~b[3:0]});
         end
      end
   endtask
endmodule // host_bus_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
`include "lcd_decoder_defines.vh"
module tb;
   // Stimulus and observed outputs
   reg aclk = 1'b0, aresetn = 1'b0, wide = 1'b1;
   reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1, i;
   reg [31:0] s_axi_wdata = 32'h0, d;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire [31:0] s_axi_rdata;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire host_strobe, command_data_select, read_write, step_increment, shift_on_write, display_enable;
   wire cursor_enable, blink_enable, bus_width_select, two_line_mode, text_target, internal_busy_flag;
   wire panel_blank, cursor_line, cursor_underline_on, blink_all_on;
   wire [7:0] host_db;
   wire [6:0] address_pointer;
   wire [4:0] display_offset, cursor_column, cursor_dot_mask;
   wire [2:0] cursor_dot_row;
   integer error_cnt = 0, checks = 0, cyc = 0, n;
   reg [6:0] ep;
   reg [4:0] eo;
   reg [7:0] rv;
   reg [1:0] rs;
   // Short blink half period keeps the run brief
   lcd_mode_and_address_decoder #(.BLINK_HALF_CYCLES(32'h8)) lcd_mode_and_address_decoder_i (.*);
   host_bus_model host_bus_model_i (.*);
   always #4 aclk = ~aclk;
   // Watchdog: a hang counts as a mismatch
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc > 5000) begin
         error_cnt = error_cnt + 1;
         summarize;
      end
   end
   // ----
   // Shared tasks
   // ----
   task summarize;
      begin
         $display("checks=%0d errors=%0d", checks, error_cnt);
         if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %s exp=%h got=%h", nm, e, g);
         end
      end
   endtask
   // Write: address and data together, each dropped once taken
   task axw(input [3:0] a, input [31:0] v, output [1:0] r);
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
         end while (s_axi_bvalid !== 1'b1);
         r = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   task axr(input [3:0] a, output [31:0] v, output [1:0] r);
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (s_axi_rvalid !== 1'b1);
         v = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task cmd(input [7:0] b);
      host_bus_model_i.send(wide, 1'b0, 1'b0, b);
   endtask
   task dat(input r);
      begin
         rv = 8'($urandom);
         host_bus_model_i.send(wide, 1'b1, r, rv);
      end
   endtask
   // Pointer and two-line offset after a shift code
   function [11:0] shift_exp(input [1:0] m, input [6:0] p, input [4:0] o);
      case (m)
         2'b00: shift_exp = {p - 7'h1, o};
         2'b01: shift_exp = {p + 7'h1, o};
         2'b10: shift_exp = {p, (o == 5'h0b) ? 5'h00 : o + 5'h1};
         default: shift_exp = {p, (o == 5'h00) ? 5'h0b : o - 5'h1};
      endcase
   endfunction
   // Main sequence
   initial begin
      n = $urandom(80711);
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axw(`REG_STATUS, 32'hffffffff, rs);
      chk("ro_bresp", `RESP_OKAY, rs);
      axw(4'hc, 32'h0, rs);
      chk("bresp", `RESP_SLVERR, rs);
      axr(4'hc, d, rs);
      chk("rresp", `RESP_SLVERR, rs);
      axr(`REG_STATUS, d, rs);
      chk("status", 32'h00080021, d);
      rv = 8'h08 | 8'($urandom % 8);
      axw(`REG_CTRL, {24'h0, rv}, rs);
      axr(`REG_CTRL, d, rs);
      chk("ctrl", rv, d);
      chk("dots", 8'hff, {cursor_dot_row, cursor_dot_mask});
      rv = 8'($urandom);
      cmd({5'h07, rv[2:0]});
      chk("func", 2'b11, {bus_width_select, two_line_mode});
      for (i = 0; i < 8; i = i + 1) begin
         cmd({5'h01, i[2:0]});
         chk("disp", i, {display_enable, cursor_enable, blink_enable});
         chk("view", {~i[2], i[2] & i[1]}, {panel_blank, cursor_underline_on});
      end
      for (i = 0; i < 4; i = i + 1) begin
         cmd({6'h01, i[1:0]});
         chk("entry", i, {step_increment, shift_on_write});
      end
      ep = 7'($urandom % 11);
      cmd({1'b1, ep});
      chk("text", {1'b1, ep}, {text_target, address_pointer});
      dat(1'b0);
      chk("inc", {ep + 7'h1, 5'h01}, {address_pointer, display_offset});
      cmd(8'h04);
      dat(1'b0);
      chk("dec", {ep, 5'h01}, {address_pointer, display_offset});
      cmd(8'h06);
      cmd(8'h8b);
      dat(1'b1);
      chk("wrap", 8'hc0, {cursor_line, address_pointer});
      cmd(8'h85);
      ep = 7'h05;
      eo = 5'h01;
      for (i = 0; i < 4; i = i + 1) begin
         rv = 8'($urandom);
         cmd({4'h1, i[1:0], rv[1:0]});
         {ep, eo} = shift_exp(i[1:0], ep, eo);
         chk("shift", {ep, eo}, {address_pointer, display_offset});
      end
      chk("column", 5'(ep[4:0] - eo), cursor_column);
      cmd(8'h5f);
      chk("glyph", 8'h1f, {text_target, address_pointer});
      dat(1'b1);
      chk("g_wrap", 7'h00, address_pointer);
      cmd(8'h0f);
      chk("busy", 1'b1, internal_busy_flag);
      host_bus_model_i.xfer(1'b0, 1'b0, 1'b0, 8'h08);
      chk("refused", 3'h7, {display_enable, cursor_enable, blink_enable});
      n = 0;
      repeat (32) begin
         @(posedge aclk);
         n = n + blink_all_on;
      end
      chk("blink", 16, n);
      cmd(8'h28);
      chk("width", 1'b0, bus_width_select);
      wide = 1'b0;
      cmd(8'h0c);
      chk("nibbles", 3'h4, {display_enable, cursor_enable, blink_enable});
      cmd(8'h38);
      wide = 1'b1;
      chk("width", 1'b1, bus_width_select);
      // Mid-run reset must bring every mode back to its start value
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axr(`REG_STATUS, d, rs);
      chk("reset", 32'h00080021, d);
      summarize;
   end
endmodule // tb
